/* core/turbo_dec_core.sv */
// turbo decoder core: apb registers, half-iteration sequencer, four soft lanes
`timescale 1ns/1ps
module turbo_dec_core (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic rd_en,
   output logic [9:0] rd_addr,
   input wire logic [23:0] rx_a,
   input wire logic [23:0] rx_b,
   input wire logic [23:0] rx_par,
   output logic wr_en,
   output logic [9:0] wr_addr,
   output logic [7:0] decoded_bits_out,
   output logic [15:0] symbol_confidence,
   output logic decode_done,
   output logic [5:0] half_iter_index,
   output logic [12:0] est_error,
   output logic busy
);
   localparam int AW = tdec_pkg::ADDR_W;
   localparam int LW = tdec_pkg::LANE_W;
   localparam int EW = tdec_pkg::EXT_W;
   localparam int NL = tdec_pkg::LANES;
   localparam int SW = 11;
   typedef logic signed [SW-1:0] sum_t;

   function automatic sum_t sm2int(input logic [5:0] v);
      // minus zero folds onto zero
      sm2int = v[5] ? -sum_t'({6'h00, v[4:0]}) : sum_t'({6'h00, v[4:0]});
   endfunction
   function automatic logic [SW-1:0] magv(input sum_t v);
      magv = v[SW-1] ? SW'(-v) : SW'(v);
   endfunction
   function automatic sum_t clampv(input sum_t v, input logic [SW-1:0] lim);
      if (v > $signed(lim)) begin
         clampv = $signed(lim);
      end else if (v < -$signed(lim)) begin
         clampv = -$signed(lim);
      end else begin
         clampv = v;
      end
   endfunction

   logic [31:0] cfg_q, cfg_d, len_q, len_d, prma_q, prma_d, prmb_q, prmb_d;
   logic [31:0] prdata_q, prdata_d;
   tdec_pkg::state_t state_q, state_d;
   logic [5:0] idx_q, idx_d, ni;
   logic [AW-1:0] n_q, n_d, cnt_q, cnt_d, acc_q, acc_d, padr_q, padr_d;
   logic [AW-1:0] win, off, base, wlen, nat, p0m, il, addr, nsel;
   logic [11:0] poff;
   logic vld_q, vld_d, chg_q, chg_d, done_q, done_d, wr_q, wr_d;
   logic [12:0] errc_q, errc_d, err_q, err_d;
   logic [AW-1:0] wadr_q, wadr_d;
   logic [7:0] dec_q, dec_d;
   logic [15:0] conf_q, conf_d;
   logic [NL*LW-1:0] ext_rd_q, ext_wr;
   logic [NL*LW-1:0] ext_mem [tdec_pkg::DEPTH];
   logic hit, wr_acc, go, first, stop, chg, log_map, scl;
   logic [3:0] ce, gain, lane_err;
   tdec_pkg::stop_t es;
   sum_t la [NL], lb [NL], ea [NL], eb [NL], sa [NL], sb [NL];
   logic [SW-1:0] ma [NL], mb [NL], mm [NL], dd [NL], lim;

   // apb decode; zero wait states so pready is constant high
   always_comb begin
      hit = paddr inside {tdec_pkg::OFS_CTRL, tdec_pkg::OFS_CFG, tdec_pkg::OFS_LEN,
         tdec_pkg::OFS_PRMA, tdec_pkg::OFS_PRMB, tdec_pkg::OFS_STAT, tdec_pkg::OFS_ERR};
      wr_acc = psel && penable && pwrite && hit;
      go = wr_acc && paddr == tdec_pkg::OFS_CTRL && pwdata[tdec_pkg::CTRL_GO]
         && state_q == tdec_pkg::ST_IDLE && nsel != '0;
      cfg_d = cfg_q;
      len_d = len_q;
      prma_d = prma_q;
      prmb_d = prmb_q;
      if (wr_acc) begin
         case (paddr)
            tdec_pkg::OFS_CFG: cfg_d = pwdata & tdec_pkg::CFG_MASK;
            tdec_pkg::OFS_LEN: len_d = pwdata & tdec_pkg::LEN_MASK;
            tdec_pkg::OFS_PRMA: prma_d = pwdata & tdec_pkg::PRMA_MASK;
            tdec_pkg::OFS_PRMB: prmb_d = pwdata & tdec_pkg::PRMB_MASK;
            default: ;
         endcase
      end
      // read data captured in the setup phase so it is a flop by access
      prdata_d = prdata_q;
      if (psel && !penable) begin
         case (paddr)
            tdec_pkg::OFS_CFG: prdata_d = cfg_q;
            tdec_pkg::OFS_LEN: prdata_d = len_q;
            tdec_pkg::OFS_PRMA: prdata_d = prma_q;
            tdec_pkg::OFS_PRMB: prdata_d = prmb_q;
            tdec_pkg::OFS_STAT: prdata_d = {23'h0, n_q == '0, idx_q, busy, done_q};
            tdec_pkg::OFS_ERR: prdata_d = {19'h0, err_q};
            default: prdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_comb begin
      pready = 1'b1;
      pslverr = psel && penable && !hit;
      prdata = prdata_q;
   end

   // configuration decode; the gain is folded so 1 acts as 0 and 2..3 as 4
   always_comb begin
      log_map = cfg_q[tdec_pkg::CFG_ALG];
      scl = cfg_q[tdec_pkg::CFG_SCL];
      es = tdec_pkg::stop_t'(cfg_q[tdec_pkg::CFG_ES +: 2]);
      ni = cfg_q[tdec_pkg::CFG_NI +: 6];
      gain = cfg_q[tdec_pkg::CFG_C +: 4];
      if (gain > tdec_pkg::C_MAX) begin
         ce = tdec_pkg::C_MAX;
      end else if (gain == 4'h1) begin
         ce = 4'h0;
      end else if (gain < tdec_pkg::C_LOG_MIN && gain != 4'h0) begin
         ce = tdec_pkg::C_LOG_MIN;
      end else begin
         ce = gain;
      end
      if (cfg_q[tdec_pkg::CFG_KS +: 5] == 5'h00) begin
         nsel = len_q[tdec_pkg::LEN_K +: AW];
      end else begin
         nsel = tdec_pkg::preset_len(cfg_q[tdec_pkg::CFG_KS +: 5]);
      end
      lim = scl ? SW'(len_q[tdec_pkg::LEN_LIM +: 8]) : SW'(tdec_pkg::EXT_MAX);
   end

   // address walk: reversed windows on even halves of blocks longer than a window, natural order otherwise; permuted order on odd ones
   always_comb begin
      win = cfg_q[tdec_pkg::CFG_WIN] ? tdec_pkg::WIN_LONG : tdec_pkg::WIN_SHORT;
      off = cnt_q & (win - 10'h001);
      base = cnt_q - off;
      wlen = (n_q - base > win) ? win : n_q - base;
      nat = (n_q > win) ? base + wlen - 10'h001 - off : cnt_q;
      case (cnt_q[1:0])
         2'h1: poff = prma_q[tdec_pkg::PRM_HI +: 12];
         2'h2: poff = prmb_q[11:0];
         2'h3: poff = prmb_q[tdec_pkg::PRM_HI +: 12];
         default: poff = 12'h000;
      endcase
      if (cfg_q[tdec_pkg::CFG_PROF]) begin
         poff = 12'h000;
      end
      p0m = AW'({4'h0, prma_q[5:0]} % n_q);
      il = AW'((13'(acc_q) + 13'(poff)) % 13'(n_q));
      addr = idx_q[0] ? il : nat;
      rd_en = state_q == tdec_pkg::ST_RUN;
      rd_addr = addr;
   end

   // four soft lanes; extrinsic memory is indexed by symbol word
   always_comb begin
      first = idx_q == 6'h00;
      ext_wr = '0;
      dec_d = '0;
      conf_d = '0;
      chg = 1'b0;
      lane_err = '0;
      for (int l = 0; l < NL; l++) begin
         sa[l] = sm2int(rx_a[l*6 +: 6]);
         sb[l] = sm2int(rx_b[l*6 +: 6]);
         ea[l] = first ? '0 : SW'($signed(ext_rd_q[l*LW +: EW]));
         eb[l] = first ? '0 : SW'($signed(ext_rd_q[l*LW+EW +: EW]));
         // punctured parity reads as zero and adds nothing
         la[l] = sa[l] + ea[l] + (sm2int(rx_par[l*6 +: 6]) >>> 1);
         lb[l] = sb[l] + eb[l] + (sm2int(rx_par[l*6 +: 6]) >>> 1);
         ext_wr[l*LW +: EW] = EW'(clampv(scl ? la[l] - (la[l] >>> 2) : la[l], lim));
         ext_wr[l*LW+EW +: EW] = EW'(clampv(scl ? lb[l] - (lb[l] >>> 2) : lb[l], lim));
         ext_wr[l*LW+2*EW] = la[l][SW-1];
         ext_wr[l*LW+2*EW+1] = lb[l][SW-1];
         dec_d[2*l +: 2] = {lb[l][SW-1], la[l][SW-1]};
         if (!first && (ext_rd_q[l*LW+2*EW +: 2] != {lb[l][SW-1], la[l][SW-1]})) begin
            chg = 1'b1;
         end
         lane_err = lane_err + 4'((rx_a[l*6+5] != la[l][SW-1]) && rx_a[l*6 +: 5] != '0)
            + 4'((rx_b[l*6+5] != lb[l][SW-1]) && rx_b[l*6 +: 5] != '0);
         // confidence: gap between best and runner-up symbol hypothesis
         ma[l] = magv(la[l]);
         mb[l] = magv(lb[l]);
         mm[l] = ma[l] < mb[l] ? ma[l] : mb[l];
         dd[l] = ma[l] > mb[l] ? ma[l] - mb[l] : mb[l] - ma[l];
         if (log_map && dd[l] < SW'(ce)) begin
            mm[l] = mm[l] - ((SW'(ce) - dd[l]) >> 1);
            if (mm[l][SW-1]) begin
               mm[l] = '0;
            end
         end
         conf_d[4*l +: 4] = (mm[l] >> 2) > SW'(tdec_pkg::CONF_MAX) ? tdec_pkg::CONF_MAX
            : 4'(mm[l] >> 2);
      end
   end

   // sequencer: one word per cycle, a drain cycle ends each half iteration
   always_comb begin
      state_d = state_q;
      idx_d = idx_q;
      n_d = n_q;
      cnt_d = cnt_q;
      acc_d = acc_q;
      done_d = done_q;
      err_d = err_q;
      vld_d = 1'b0;
      padr_d = addr;
      chg_d = chg_q || (vld_q && chg);
      errc_d = vld_q ? errc_q + 13'(lane_err) : errc_q;
      stop = 1'b0;
      unique case (state_q)
         tdec_pkg::ST_IDLE: begin
            if (go) begin
               state_d = tdec_pkg::ST_RUN;
               n_d = nsel;
               idx_d = '0;
               cnt_d = '0;
               acc_d = '0;
               done_d = 1'b0;
               chg_d = 1'b0;
               errc_d = '0;
            end
         end
         tdec_pkg::ST_RUN: begin
            vld_d = 1'b1;
            cnt_d = cnt_q + 10'h001;
            acc_d = ({1'b0, acc_q} + {1'b0, p0m} >= {1'b0, n_q}) ? acc_q + p0m - n_q
               : acc_q + p0m;
            if (cnt_q == n_q - 10'h001) begin
               state_d = tdec_pkg::ST_END;
            end
         end
         tdec_pkg::ST_END: begin
            stop = idx_q == ni;
            if (!chg_d && !first) begin
               case (es)
                  tdec_pkg::ES_ODD: stop = stop || idx_q[0];
                  tdec_pkg::ES_EVEN: stop = stop || !idx_q[0];
                  tdec_pkg::ES_ANY: stop = 1'b1;
                  default: ;
               endcase
            end
            cnt_d = '0;
            acc_d = '0;
            chg_d = 1'b0;
            errc_d = '0;
            if (stop) begin
               state_d = tdec_pkg::ST_IDLE;
               done_d = 1'b1;
               err_d = errc_q + 13'(vld_q ? lane_err : 4'h0);
            end else begin
               state_d = tdec_pkg::ST_RUN;
               idx_d = idx_q + 6'h01;
            end
         end
      endcase
      wr_d = vld_q && !(cfg_q[tdec_pkg::CFG_KS +: 5] == tdec_pkg::KS_SPECIAL && idx_q[0]);
      wadr_d = padr_q;
   end

   always_comb begin
      busy = state_q != tdec_pkg::ST_IDLE;
      decode_done = done_q;
      half_iter_index = idx_q;
      est_error = err_q;
      wr_en = wr_q;
      wr_addr = wadr_q;
      decoded_bits_out = dec_q;
      symbol_confidence = conf_q;
   end

   // extrinsic store has no reset; the first half iteration ignores it
   always_ff @(posedge clk) begin
      ext_rd_q <= ext_mem[addr];
      if (vld_q) begin
         ext_mem[padr_q] <= ext_wr;
      end
   end

   // all resettable state of the single clock domain
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfg_q <= tdec_pkg::CFG_RST;
         len_q <= tdec_pkg::LEN_RST;
         prma_q <= '0;
         prmb_q <= '0;
         prdata_q <= '0;
         state_q <= tdec_pkg::ST_IDLE;
         idx_q <= '0;
         n_q <= 10'h001;
         cnt_q <= '0;
         acc_q <= '0;
         padr_q <= '0;
         vld_q <= 1'b0;
         chg_q <= 1'b0;
         done_q <= 1'b0;
         errc_q <= '0;
         err_q <= '0;
         wr_q <= 1'b0;
         wadr_q <= '0;
         dec_q <= '0;
         conf_q <= '0;
      end else begin
         cfg_q <= cfg_d;
         len_q <= len_d;
         prma_q <= prma_d;
         prmb_q <= prmb_d;
         prdata_q <= prdata_d;
         state_q <= state_d;
         idx_q <= idx_d;
         n_q <= n_d;
         cnt_q <= cnt_d;
         acc_q <= acc_d;
         padr_q <= padr_d;
         vld_q <= vld_d;
         chg_q <= chg_d;
         done_q <= done_d;
         errc_q <= errc_d;
         err_q <= err_d;
         wr_q <= wr_d;
         wadr_q <= wadr_d;
         dec_q <= vld_q ? dec_d : dec_q;
         conf_q <= vld_q ? conf_d : conf_q;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_start;
      go;
   endsequence
   sequence s_last;
      state_q == tdec_pkg::ST_END && idx_q == ni;
   endsequence

   done_hold_a: assert property (done_q && !go |=> done_q)
      else $error("done dropped without a start");
   start_clear_a: assert property (s_start |=> busy && !done_q && idx_q == 6'h00)
      else $error("start did not clear done and index");
   last_half_a: assert property (s_last |=> done_q && !busy)
      else $error("run passed the configured half count");
   no_early_a: assert property (state_q == tdec_pkg::ST_END && es == tdec_pkg::ES_NONE
      && idx_q != ni |=> !done_q && idx_q == $past(idx_q) + 6'h01)
      else $error("stopped early with early stop off");
   conf_cap_a: assert property (wr_en |-> symbol_confidence[3:0] <= tdec_pkg::CONF_MAX
      && symbol_confidence[15:12] <= tdec_pkg::CONF_MAX)
      else $error("confidence above 14");
   special_odd_a: assert property (vld_q && idx_q[0]
      && cfg_q[tdec_pkg::CFG_KS +: 5] == tdec_pkg::KS_SPECIAL |=> !wr_en)
      else $error("preset 11 wrote on odd half");
   rev_window_a: assert property (state_q == tdec_pkg::ST_RUN && cnt_q == '0
      && !idx_q[0] && n_q > win |-> rd_addr == win - 10'h001)
      else $error("window not walked in reverse");
   write_follow_a: assert property (rd_en ##1 vld_q |=> wr_en
      || $past(idx_q[0] && cfg_q[tdec_pkg::CFG_KS +: 5] == tdec_pkg::KS_SPECIAL))
      else $error("read word not written out");
   apb_err_a: assert property (psel && penable && !hit |-> pslverr && prdata == '0)
      else $error("unmapped access without error");
endmodule // turbo_dec_core

/* shared/tdec_pkg.sv */
// constants, register map and state types of the turbo decoder core
package tdec_pkg;
   localparam int ADDR_W = 10;
   localparam int DEPTH = 608;
   localparam int LANES = 4;
   localparam int SOFT_W = 6;
   localparam int EXT_W = 9;
   localparam int LANE_W = 2 * EXT_W + 2;
   localparam int ERR_W = 13;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CFG = 8'h04;
   localparam logic [7:0] OFS_LEN = 8'h08;
   localparam logic [7:0] OFS_PRMA = 8'h0C;
   localparam logic [7:0] OFS_PRMB = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h14;
   localparam logic [7:0] OFS_ERR = 8'h18;
   localparam logic [31:0] CFG_MASK = 32'h001F_FFFF;
   localparam logic [31:0] LEN_MASK = 32'h00FF_1FF8;
   localparam logic [31:0] PRMA_MASK = 32'h0FFE_003E;
   localparam logic [31:0] PRMB_MASK = 32'h0FFE_0FFE;
   localparam logic [31:0] CFG_RST = 32'h0000_4800;
   localparam logic [31:0] LEN_RST = 32'h007F_0030;
   localparam int CTRL_GO = 0;
   localparam int CFG_ALG = 0;
   localparam int CFG_SCL = 1;
   localparam int CFG_ES = 2;
   localparam int CFG_PROF = 4;
   localparam int CFG_WIN = 5;
   localparam int CFG_KS = 6;
   localparam int CFG_NI = 11;
   localparam int CFG_C = 17;
   localparam int LEN_K = 3;
   localparam int LEN_LIM = 16;
   localparam int PRM_HI = 16;
   localparam logic [ADDR_W-1:0] WIN_SHORT = 10'h020;
   localparam logic [ADDR_W-1:0] WIN_LONG = 10'h040;
   localparam logic [4:0] KS_SPECIAL = 5'h0B;
   localparam logic [3:0] C_MAX = 4'hB;
   localparam logic [3:0] C_LOG_MIN = 4'h4;
   localparam logic [3:0] CONF_MAX = 4'hE;
   localparam logic [EXT_W-1:0] EXT_MAX = 9'h0FF;
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_END = 2'b11} state_t;
   typedef enum logic [1:0] {ES_NONE = 2'b00, ES_ODD = 2'b01, ES_EVEN = 2'b10,
      ES_ANY = 2'b11} stop_t;
   // block length in words of eight bits for each preset code
   function automatic logic [ADDR_W-1:0] preset_len(input logic [4:0] ks);
      case (ks)
         5'h01: preset_len = 10'h006;
         5'h02: preset_len = 10'h00C;
         5'h03: preset_len = 10'h012;
         5'h04: preset_len = 10'h018;
         5'h05: preset_len = 10'h01E;
         5'h06: preset_len = 10'h024;
         5'h07: preset_len = 10'h030;
         5'h08: preset_len = 10'h036;
         5'h09: preset_len = 10'h03C;
         5'h0A: preset_len = 10'h009;
         5'h0B: preset_len = 10'h01B;
         5'h0C: preset_len = 10'h02D;
         5'h0D: preset_len = 10'h078;
         5'h0E: preset_len = 10'h0F0;
         5'h0F: preset_len = 10'h168;
         5'h10: preset_len = 10'h1E0;
         5'h11: preset_len = 10'h258;
         default: preset_len = 10'h000;
      endcase
   endfunction
endpackage

/* verif/rx_mem_model.sv */
// input-memory model that feeds soft received words to the decoder
`timescale 1ns/1ps
module rx_mem_model (
   input wire logic clk,
   input wire logic rd_en,
   input wire logic [9:0] rd_addr,
   input wire logic punct,
   output logic [23:0] rx_a,
   output logic [23:0] rx_b,
   output logic [23:0] rx_par
);
   // four sign-magnitude lanes; the sign follows address bits so words differ
   function automatic logic [23:0] word(input logic [9:0] a, input logic [4:0] mag);
      logic [23:0] w;
      for (int l = 0; l < 4; l++) begin
         w[6*l +: 6] = {a[l] ^ a[l+4], mag};
      end
      return w;
   endfunction

   initial begin
      rx_a = 24'h000000;
      rx_b = 24'h000000;
      rx_par = 24'h000000;
   end

   // one-cycle read latency; between reads the bus toggles so stale data never looks valid
   always @(posedge clk) begin
      if (rd_en) begin
         rx_a <= word(rd_addr, 5'h14);
         rx_b <= word(rd_addr ^ 10'h005, 5'h0C);
         rx_par <= punct ? 24'h000000 : word(~rd_addr, 5'h0A);
      end else begin
         rx_a <= ~rx_a;
         rx_b <= ~rx_b;
         rx_par <= ~rx_par;
      end
   end
endmodule // rx_mem_model

/* verif/test_duobinary_turbo_decoder.sv */
// self-checking bench for the turbo decoder core over its register bus
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); n_errors++; end end
module test_duobinary_turbo_decoder;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h00000000;
   logic punct = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, rd_en, wr_en, decode_done, busy;
   logic [9:0] rd_addr, wr_addr;
   logic [23:0] rx_a, rx_b, rx_par;
   logic [7:0] decoded_bits_out;
   logic [15:0] symbol_confidence;
   logic [5:0] half_iter_index;
   logic [12:0] est_error;
   int n_errors = 0;
   int compares = 0;
   logic [31:0] rdat;
   logic rerr;
   int nwr;
   logic [5:0] idx;
   logic [9:0] first;
   logic [7:0] dec0;
   logic [7:0] reg_addr [7] = '{tdec_pkg::OFS_CTRL, tdec_pkg::OFS_CFG, tdec_pkg::OFS_LEN,
      tdec_pkg::OFS_PRMA, tdec_pkg::OFS_PRMB, tdec_pkg::OFS_STAT, tdec_pkg::OFS_ERR};
   logic [31:0] reg_rst [7] = '{32'h0, tdec_pkg::CFG_RST, tdec_pkg::LEN_RST, 32'h0, 32'h0,
      32'h0, 32'h0};
   logic [31:0] reg_mask [7] = '{32'h0, tdec_pkg::CFG_MASK, tdec_pkg::LEN_MASK,
      tdec_pkg::PRMA_MASK, tdec_pkg::PRMB_MASK, 32'h0, 32'h0};
   int bits_tab [17] = '{48, 96, 144, 192, 240, 288, 384, 432, 480, 72, 216, 360, 960, 1920,
      2880, 3840, 4800};

   always #12.5 clk = ~clk;

   turbo_dec_core turbo_dec_core_i (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rd_en(rd_en), .rd_addr(rd_addr), .rx_a(rx_a), .rx_b(rx_b),
      .rx_par(rx_par), .wr_en(wr_en), .wr_addr(wr_addr), .decoded_bits_out(decoded_bits_out),
      .symbol_confidence(symbol_confidence), .decode_done(decode_done),
      .half_iter_index(half_iter_index), .est_error(est_error), .busy(busy));

   rx_mem_model rx_mem_model_i (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr), .punct(punct),
      .rx_a(rx_a), .rx_b(rx_b), .rx_par(rx_par));

   task automatic finish_test();
      if (n_errors == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // one bus transfer: setup, then access held until pready is seen at an edge
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 50) begin
         n_errors++;
         finish_test();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [31:0] mk(input logic [4:0] pre, input logic [5:0] ni,
         input logic [1:0] es, input logic [1:0] alg_scl);
      return 32'(alg_scl) | (32'(es) << tdec_pkg::CFG_ES) | (32'(pre) << tdec_pkg::CFG_KS)
         | (32'(ni) << tdec_pkg::CFG_NI) | (32'h6 << tdec_pkg::CFG_C);
   endfunction

   // configure, start, and count output words until done; bounded against a hang
   task automatic run(input logic [31:0] cfg);
      int i;
      apb(tdec_pkg::OFS_CFG, 1'b1, cfg);
      apb(tdec_pkg::OFS_CTRL, 1'b1, 32'h00000001);
      nwr = 0;
      for (i = 0; i < 20000; i++) begin
         @(posedge clk);
         #1;
         if (wr_en === 1'b1) begin
            if (nwr == 0) begin
               first = wr_addr;
               dec0 = decoded_bits_out;
            end
            nwr++;
            for (int l = 0; l < 4; l++) `CHK(symbol_confidence[4*l +: 4] <= 4'hE, 1'b1)
         end
         if (decode_done === 1'b1) break;
      end
      if (i == 20000) begin
         n_errors++;
         finish_test();
      end
      idx = half_iter_index;
      `CHK(busy, 1'b0)
   endtask

   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      // reset values, then write-ones readback shows the writable fields only
      for (int r = 0; r < 7; r++) begin
         apb(reg_addr[r], 1'b0, 32'h0);
         `CHK(rdat, reg_rst[r])
      end
      for (int r = 1; r < 7; r++) begin
         apb(reg_addr[r], 1'b1, 32'hFFFFFFFF);
         apb(reg_addr[r], 1'b0, 32'h0);
         `CHK(rdat, reg_mask[r])
      end
      apb(8'h1C, 1'b0, 32'h0);
      `CHK(rerr, 1'b1)
      `CHK(rdat, 32'h00000000)
      // zero length must refuse the start: no run, no done, index stays 0
      apb(tdec_pkg::OFS_LEN, 1'b1, 32'h0);
      apb(tdec_pkg::OFS_CFG, 1'b1, mk(5'h00, 6'h00, 2'b00, 2'b00));
      apb(tdec_pkg::OFS_CTRL, 1'b1, 32'h00000001);
      apb(tdec_pkg::OFS_STAT, 1'b0, 32'h0);
      `CHK(rdat[8:0], 9'h000)
      `CHK(busy, 1'b0)
      // explicit length of six words, log algorithm with scaling, punctured parity
      apb(tdec_pkg::OFS_LEN, 1'b1, 32'h00C00030);
      apb(tdec_pkg::OFS_PRMA, 1'b1, 32'h00060006);
      apb(tdec_pkg::OFS_PRMB, 1'b1, 32'h000A000A);
      punct <= 1'b1;
      run(mk(5'h00, 6'h01, 2'b00, 2'b11));
      `CHK(nwr, 12)
      `CHK(idx, 6'h01)
      `CHK(first, 10'h000)
      `CHK(dec0, 8'h22)
      `CHK(est_error, 13'h0000)
      apb(tdec_pkg::OFS_ERR, 1'b0, 32'h0);
      `CHK(rdat[12:0], est_error)
      apb(tdec_pkg::OFS_STAT, 1'b0, 32'h0);
      `CHK(rdat[1:0], 2'b01)
      punct <= 1'b0;
      // every preset size, one half iteration each; long blocks start at a window's top
      for (int p = 1; p <= 17; p++) begin
         run(mk(5'(p), 6'h00, 2'b00, 2'b00));
         `CHK(nwr, bits_tab[p-1] / 8)
         `CHK(first, 10'((bits_tab[p-1] / 8 > 32) ? 31 : 0))
         `CHK(dec0, (bits_tab[p-1] / 8 > 32) ? 8'hDE : 8'h22)
      end
      run(mk(5'h11, 6'h00, 2'b00, 2'b00) | (32'h1 << tdec_pkg::CFG_WIN));
      `CHK(first, 10'd63)
      run(mk(5'h0B, 6'h01, 2'b00, 2'b00));
      `CHK(nwr, 27)
      // single-access family on the explicit six-word block, both halves written
      run(mk(5'h00, 6'h01, 2'b00, 2'b00) | (32'h1 << tdec_pkg::CFG_PROF));
      `CHK(nwr, 12)
      // full 64-half run, then each early-stop mode
      for (int m = 0; m < 4; m++) begin
         run(mk(5'h01, 6'h3F, 2'(m), 2'b00));
         if (m == 0) begin
            `CHK(idx, 6'h3F)
            `CHK(nwr, 384)
         end else if (m == 3) begin
            `CHK(idx < 6'h3F, 1'b1)
         end else begin
            `CHK(idx == 6'h3F || idx[0] == (m == 1), 1'b1)
         end
      end
      finish_test();
   end
endmodule // test_duobinary_turbo_decoder
